// ### rtl/ocp_pkg.sv
// Purpose: shared constants and types for the output compare channel
// Assumes: 16-bit timers, registers in the low half of 32-bit words
// Notes:   control word layout packed by functions below
package ocp_pkg;

    localparam int          CNT_W        = 16;
    localparam int          ADDR_W       = 8;
    localparam logic [7:0]  ADDR_CTRL    = 8'h00;
    localparam logic [7:0]  ADDR_DUTY    = 8'h04;
    localparam logic [7:0]  ADDR_BUFFER  = 8'h08;
    localparam logic [7:0]  ADDR_FLAG    = 8'h0c;
    localparam int          BIT_HALT     = 13;
    localparam int          BIT_FAULT    = 4;
    localparam int          BIT_TSEL     = 3;
    localparam int          MODE_MSB     = 2;
    localparam int          BIT_IFLAG    = 0;
    localparam logic [1:0]  RESP_OKAY    = 2'b00;
    localparam logic [1:0]  RESP_SLVERR  = 2'b10;
    localparam logic [15:0] DUTY_RESET   = 16'h0000;
    localparam int          FAULT_B_CHAN = 5;

    typedef enum logic [2:0] {
        MODE_OFF       = 3'b000,
        MODE_RISE      = 3'b001,
        MODE_FALL      = 3'b010,
        MODE_TOGGLE    = 3'b011,
        MODE_SINGLE    = 3'b100,
        MODE_CONT      = 3'b101,
        MODE_PWM       = 3'b110,
        MODE_PWM_FAULT = 3'b111
    } ocp_mode_type;

    typedef enum logic [2:0] {
        PS_WAIT_RISE = 3'b001,
        PS_WAIT_FALL = 3'b010,
        PS_DONE      = 3'b100
    } ocp_pulse_type;

    typedef struct packed {
        logic         halt_in_idle;
        logic         timebase_select;
        ocp_mode_type compare_mode_select;
    } ocp_ctrl_type;

    typedef struct packed {
        logic [CNT_W-1:0] timer_count;
        logic [CNT_W-1:0] timer_period_value;
    } ocp_timer_type;

    localparam ocp_ctrl_type CTRL_RESET = '{1'b0, 1'b0, MODE_OFF};

    function automatic logic [31:0] ctrl_to_word(input ocp_ctrl_type c, input logic flt);
        logic [31:0] w;
        w                    = 32'h0000_0000;
        w[BIT_HALT]          = c.halt_in_idle;
        w[BIT_FAULT]         = flt;
        w[BIT_TSEL]          = c.timebase_select;
        w[MODE_MSB:0]        = c.compare_mode_select;
        return w;
    endfunction : ctrl_to_word

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] strb);
        logic [15:0] r;
        r       = old;
        if (strb[0]) r[7:0]  = d[7:0];
        if (strb[1]) r[15:8] = d[15:8];
        return r;
    endfunction : merge16

endpackage : ocp_pkg

// ### rtl/ocp_channel.sv
// Purpose: one output compare / pwm channel behind an AXI4-Lite slave
// Assumes: timers and cpu idle are same-clock logic; fault pins are async
// Notes:   compare events are taken when the selected timer count changes
//
// What this block does
// - pwm period spans timer period value plus one counts.
// - duty buffer copied into active duty only on period match.
// - active duty ignores software writes in both pwm modes.
// - active duty zero keeps output low all period.
// - active duty above period value keeps output high.
// - duty equal to period gives one low count per period.
// - halt_in_idle set stops the channel while cpu is idle.
// - fault status set by hardware, cleared only by a software mode write to control.
// - timebase_select one picks timer3, zero picks timer2.
// - mode 111 pwm honours fault, mode 110 ignores it.
// - mode 101 starts low then repeats pulses.
// - mode 100 starts low then makes exactly one pulse.
// - mode 011 inverts output on every compare match.
// - mode 010 starts high, compare match drives low.
// - mode 001 starts low, compare match drives high.
// - mode 000 disables channel, compare events do nothing.
// - fault input a serves channels one to four, b channel five.
// - control bits 15-14 and 12-5 ignore writes, read zero.
// - single pulse rises on primary, falls on secondary, sets flag.
// - continuous pulse sets flag on every secondary match that ends a pulse.
// - timer wraps to zero at period match, marking each period.
// - active duty held at pwm entry serves the first period.
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
module ocp_channel
    import ocp_pkg::*;
#(
    parameter int CHANNEL_NUMBER = 1
) (
    // clock and reset
    input  wire logic                  CORE_CLK,
    input  wire logic                  RST,
    // axi4-lite write
    input  wire logic [ocp_pkg::ADDR_W-1:0] AWADDR,
    input  wire logic                  AWVALID,
    output logic                       AWREADY,
    input  wire logic [31:0]           WDATA,
    input  wire logic [3:0]            WSTRB,
    input  wire logic                  WVALID,
    output logic                       WREADY,
    output logic [1:0]                 BRESP,
    output logic                       BVALID,
    input  wire logic                  BREADY,
    // axi4-lite read
    input  wire logic [ocp_pkg::ADDR_W-1:0] ARADDR,
    input  wire logic                  ARVALID,
    output logic                       ARREADY,
    output logic [31:0]                RDATA,
    output logic [1:0]                 RRESP,
    output logic                       RVALID,
    input  wire logic                  RREADY,
    // time bases and system state
    input  wire ocp_pkg::ocp_timer_type TIMER2,
    input  wire ocp_pkg::ocp_timer_type TIMER3,
    input  wire logic                  CPU_IDLE,
    // fault pins, active low
    input  wire logic                  FAULT_INPUT_A_N,
    input  wire logic                  FAULT_INPUT_B_N,
    // channel outputs
    output logic                       COMPARE_OUTPUT_PIN,
    output logic                       COMPARE_OUTPUT_OE,
    output logic                       CHANNEL_INTERRUPT_FLAG
);

    // bus state
    logic              awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic              aw_have_reg, w_have_reg;
    logic [ADDR_W-1:0] waddr_reg;
    logic [31:0]       wdata_reg;
    logic [3:0]        wstrb_reg;
    logic [1:0]        bresp_reg, rresp_reg;
    logic [31:0]       rdata_reg;
    // channel state
    ocp_ctrl_type      ctrl_reg, ctrl_next;
    logic              fault_status_reg, fault_status_next;
    logic [CNT_W-1:0]  primary_reg, primary_next;
    logic [CNT_W-1:0]  secondary_reg, secondary_next;
    logic [CNT_W-1:0]  prev_count_reg;
    ocp_pulse_type     pulse_reg, pulse_next;
    logic              out_reg, out_next;
    logic              oe_reg, oe_next;
    logic              flag_reg, flag_next;
    logic              fault_meta_reg, fault_sync_reg;
    logic              event_hit;

    // write channel decode
    wire               aw_fire    = AWVALID & awready_reg;
    wire               w_fire     = WVALID & wready_reg;
    wire               commit     = aw_have_reg & w_have_reg & ~bvalid_reg;
    wire               aw_have_nx = ~commit & (aw_have_reg | aw_fire);
    wire               w_have_nx  = ~commit & (w_have_reg | w_fire);
    wire               bvalid_nx  = commit | (bvalid_reg & ~BREADY);
    wire               wr_ctrl    = commit & (waddr_reg == ADDR_CTRL);
    wire               wr_duty    = commit & (waddr_reg == ADDR_DUTY);
    wire               wr_buffer  = commit & (waddr_reg == ADDR_BUFFER);
    wire               wr_flag    = commit & (waddr_reg == ADDR_FLAG);
    wire               wr_mapped  = wr_ctrl | wr_duty | wr_buffer | wr_flag;
    wire               mode_write = wr_ctrl & wstrb_reg[0];
    wire ocp_mode_type wr_mode    = ocp_mode_type'(wdata_reg[MODE_MSB:0]);
    wire               flag_clear = wr_flag & wstrb_reg[0] & wdata_reg[BIT_IFLAG];

    // read channel decode
    wire               ar_fire    = ARVALID & arready_reg;
    wire               rvalid_nx  = ar_fire | (rvalid_reg & ~RREADY);
    wire               rd_mapped  = (ARADDR == ADDR_CTRL) | (ARADDR == ADDR_DUTY) |
                                    (ARADDR == ADDR_BUFFER) | (ARADDR == ADDR_FLAG);
    wire [31:0]        rd_word    =
        (ARADDR == ADDR_CTRL)   ? ctrl_to_word(ctrl_reg, fault_status_reg) :
        (ARADDR == ADDR_DUTY)   ? {16'h0000, primary_reg} :
        (ARADDR == ADDR_BUFFER) ? {16'h0000, secondary_reg} :
        (ARADDR == ADDR_FLAG)   ? {31'h0000_0000, flag_reg} : 32'h0000_0000;

    // time base and compare decode
    wire ocp_mode_type   mode       = ctrl_reg.compare_mode_select;
    wire ocp_timer_type  sel_timer  = ctrl_reg.timebase_select ? TIMER3 : TIMER2;
    wire [CNT_W-1:0]     count      = sel_timer.timer_count;
    wire [CNT_W-1:0]     period     = sel_timer.timer_period_value;
    wire                 running    = ~(ctrl_reg.halt_in_idle & CPU_IDLE);
    wire                 tick       = running & (count != prev_count_reg);
    wire                 period_hit = tick & (count == period);
    wire                 primary_hit   = tick & (count == primary_reg);
    wire                 secondary_hit = tick & (count == secondary_reg);
    wire                 is_pwm     = (mode == MODE_PWM) | (mode == MODE_PWM_FAULT);
    wire                 fault_now  = (mode == MODE_PWM_FAULT) & fault_sync_reg;
    wire ocp_mode_type   mode_after = mode_write ? wr_mode : mode;
    // channel five watches the second fault pin
    wire                 fault_pin_n = (CHANNEL_NUMBER == FAULT_B_CHAN) ?
                                       FAULT_INPUT_B_N : FAULT_INPUT_A_N;

    always_comb begin
        ctrl_next = ctrl_reg;
        if (wr_ctrl & wstrb_reg[1]) ctrl_next.halt_in_idle = wdata_reg[BIT_HALT];
        if (mode_write) begin
            ctrl_next.timebase_select     = wdata_reg[BIT_TSEL];
            ctrl_next.compare_mode_select = wr_mode;
        end
    end

    // fault status: set wins over the clear made by a mode rewrite
    assign fault_status_next = fault_now | (fault_status_reg & ~mode_write);

    // active duty: period-match transfer, software only outside pwm
    always_comb begin
        primary_next = primary_reg;
        if (is_pwm & period_hit) primary_next = secondary_reg;
        else if (wr_duty & ~is_pwm) primary_next = merge16(primary_reg, wdata_reg, wstrb_reg);
    end

    assign secondary_next = wr_buffer ? merge16(secondary_reg, wdata_reg, wstrb_reg)
                                      : secondary_reg;

    // output sequencing per mode
    always_comb begin
        out_next  = out_reg;
        pulse_next = pulse_reg;
        event_hit = 1'b0;
        if (mode_write) begin
            out_next   = (wr_mode == MODE_FALL);
            pulse_next = PS_WAIT_RISE;
        end else if (tick) begin
            case (mode)
                MODE_RISE: begin
                    if (primary_hit) begin
                        out_next  = 1'b1;
                        event_hit = 1'b1;
                    end
                end
                MODE_FALL: begin
                    if (primary_hit) begin
                        out_next  = 1'b0;
                        event_hit = 1'b1;
                    end
                end
                MODE_TOGGLE: begin
                    if (primary_hit) begin
                        out_next  = ~out_reg;
                        event_hit = 1'b1;
                    end
                end
                MODE_SINGLE, MODE_CONT: begin
                    case (pulse_reg)
                        PS_WAIT_RISE: begin
                            if (primary_hit) begin
                                out_next   = 1'b1;
                                pulse_next = PS_WAIT_FALL;
                            end
                        end
                        PS_WAIT_FALL: begin
                            if (secondary_hit) begin
                                out_next   = 1'b0;
                                event_hit  = 1'b1;
                                pulse_next = (mode == MODE_SINGLE) ? PS_DONE
                                                                   : PS_WAIT_RISE;
                            end
                        end
                        PS_DONE: pulse_next = PS_DONE;
                        default: pulse_next = PS_WAIT_RISE;
                    endcase
                end
                MODE_PWM, MODE_PWM_FAULT: begin
                    out_next = (count < primary_reg);
                end
                default: out_next = out_reg;
            endcase
        end
        if (fault_status_next) out_next = 1'b0;
    end

    assign oe_next   = (mode_after != MODE_OFF) & ~fault_status_next;
    // a standing fault keeps the flag up, so set wins over a clear
    assign flag_next = event_hit | fault_now |
                       (flag_reg & ~flag_clear);

    // bus registers
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
            aw_have_reg <= 1'b0;
            w_have_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b0;
        end else begin
            aw_have_reg <= aw_have_nx;
            w_have_reg  <= w_have_nx;
            bvalid_reg  <= bvalid_nx;
            awready_reg <= ~aw_have_nx & ~bvalid_nx;
            wready_reg  <= ~w_have_nx & ~bvalid_nx;
            rvalid_reg  <= rvalid_nx;
            arready_reg <= ~rvalid_nx;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            waddr_reg <= '0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            bresp_reg <= RESP_OKAY;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= RESP_OKAY;
        end else begin
            if (aw_fire) waddr_reg <= AWADDR;
            if (w_fire) begin
                wdata_reg <= WDATA;
                wstrb_reg <= WSTRB;
            end
            if (commit) bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            if (ar_fire) begin
                rdata_reg <= rd_word;
                rresp_reg <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // channel registers
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            ctrl_reg         <= CTRL_RESET;
            fault_status_reg <= 1'b0;
            primary_reg      <= DUTY_RESET;
            secondary_reg    <= DUTY_RESET;
            prev_count_reg   <= '0;
            pulse_reg        <= PS_WAIT_RISE;
            out_reg          <= 1'b0;
            oe_reg           <= 1'b0;
            flag_reg         <= 1'b0;
            fault_meta_reg   <= 1'b0;
            fault_sync_reg   <= 1'b0;
        end else begin
            ctrl_reg         <= ctrl_next;
            fault_status_reg <= fault_status_next;
            primary_reg      <= primary_next;
            secondary_reg    <= secondary_next;
            if (running) prev_count_reg <= count;
            pulse_reg        <= pulse_next;
            out_reg          <= out_next;
            oe_reg           <= oe_next;
            flag_reg         <= flag_next;
            fault_meta_reg   <= ~fault_pin_n;
            fault_sync_reg   <= fault_meta_reg;
        end
    end

    assign AWREADY                = awready_reg;
    assign WREADY                 = wready_reg;
    assign BVALID                 = bvalid_reg;
    assign BRESP                  = bresp_reg;
    assign ARREADY                = arready_reg;
    assign RVALID                 = rvalid_reg;
    assign RDATA                  = rdata_reg;
    assign RRESP                  = rresp_reg;
    assign COMPARE_OUTPUT_PIN     = out_reg;
    assign COMPARE_OUTPUT_OE      = oe_reg;
    assign CHANNEL_INTERRUPT_FLAG = flag_reg;

    // checks
    sequence s_pwm_tick;
        is_pwm & tick & ~mode_write & ~fault_status_next;
    endsequence

    chk_duty_transfer: assert property (@(posedge CORE_CLK) disable iff (RST)
        is_pwm & period_hit |=> primary_reg == $past(secondary_reg))
        else $error("duty buffer not transferred at period match");
    chk_duty_locked: assert property (@(posedge CORE_CLK) disable iff (RST)
        is_pwm & ~period_hit |=> $stable(primary_reg))
        else $error("active duty changed outside period match");
    chk_zero_duty: assert property (@(posedge CORE_CLK) disable iff (RST)
        s_pwm_tick ##0 (primary_reg == '0) |=> ~out_reg)
        else $error("zero duty drove output high");
    chk_full_duty: assert property (@(posedge CORE_CLK) disable iff (RST)
        s_pwm_tick ##0 (primary_reg > period) |=> out_reg)
        else $error("duty above period did not hold output high");
    chk_equal_duty: assert property (@(posedge CORE_CLK) disable iff (RST)
        s_pwm_tick ##0 (primary_reg == period) |=> out_reg == ($past(count) != $past(period)))
        else $error("duty equal to period gave wrong level");
    chk_idle_halt: assert property (@(posedge CORE_CLK) disable iff (RST)
        ctrl_reg.halt_in_idle & CPU_IDLE & ~mode_write & ~fault_now |=> $stable(out_reg))
        else $error("output moved while halted in idle");
    chk_fault_status: assert property (@(posedge CORE_CLK) disable iff (RST)
        fault_now |=> fault_status_reg & flag_reg & ~COMPARE_OUTPUT_OE)
        else $error("fault did not set status and flag or cut drive");
    chk_fault_hold: assert property (@(posedge CORE_CLK) disable iff (RST)
        fault_status_reg & ~mode_write |=> fault_status_reg)
        else $error("fault status cleared without mode rewrite");
    chk_toggle_edge: assert property (@(posedge CORE_CLK) disable iff (RST)
        (mode == MODE_TOGGLE) & primary_hit & ~mode_write |=> out_reg != $past(out_reg))
        else $error("toggle mode did not invert output");
    chk_single_done: assert property (@(posedge CORE_CLK) disable iff (RST)
        (mode == MODE_SINGLE) & (pulse_reg == PS_DONE) & ~mode_write |=> ~out_reg [*2])
        else $error("single pulse mode produced a second pulse");
    chk_mode_entry: assert property (@(posedge CORE_CLK) disable iff (RST)
        mode_write & (wr_mode == MODE_FALL) & ~fault_now |=> out_reg & COMPARE_OUTPUT_OE)
        else $error("mode 010 entry did not drive high");
    chk_off_quiet: assert property (@(posedge CORE_CLK) disable iff (RST)
        (mode == MODE_OFF) & ~mode_write |=> $stable(out_reg) & ~COMPARE_OUTPUT_OE)
        else $error("disabled channel changed output");

endmodule : ocp_channel

// ### tb/ocp_load.sv
// Purpose: load stage hanging on the compare pin
// Assumes: pin is pulled low whenever the channel stops driving it
// Notes:   trip makes the stage pull the active low fault line
`timescale 1ns/1ps
module ocp_load (
    // pin side
    input  wire logic PIN,
    input  wire logic OE,
    // stage state
    input  wire logic TRIP,
    output logic      LEVEL,
    output logic      FAULT_N
);
    // undriven pin falls to the pull-down level
    assign LEVEL   = OE ? PIN : 1'b0;
    assign FAULT_N = ~TRIP;
endmodule : ocp_load

// ### tb/test_ocp_channel.sv
// Purpose: self-checking bench for the compare channel
// Assumes: timer2 counts every clock with a short period, timer3 stands still
// Notes:   pin counts are taken over whole timer periods
`timescale 1ns/1ps
module test_ocp_channel;
    import ocp_pkg::*;
    localparam logic [15:0] PER = 16'h0003;
    logic          CORE_CLK = 1'b0;
    logic          RST      = 1'b1;
    logic [7:0]    AWADDR   = 8'h00;
    logic [7:0]    ARADDR   = 8'h00;
    logic          AWVALID  = 1'b0;
    logic          WVALID   = 1'b0;
    logic          BREADY   = 1'b0;
    logic          ARVALID  = 1'b0;
    logic          RREADY   = 1'b0;
    logic [31:0]   WDATA    = 32'h0;
    logic [3:0]    WSTRB    = 4'hf;
    logic          CPU_IDLE = 1'b0;
    logic          FAULT_INPUT_B_N = 1'b1;
    logic          trip     = 1'b0;
    logic [15:0]   cnt2     = 16'h0000;
    logic          AWREADY, WREADY, BVALID, ARREADY, RVALID, level;
    logic [1:0]    BRESP, RRESP, rr, br;
    logic [31:0]   RDATA, rv;
    ocp_timer_type TIMER2, TIMER3;
    logic          FAULT_INPUT_A_N, COMPARE_OUTPUT_PIN, COMPARE_OUTPUT_OE, CHANNEL_INTERRUPT_FLAG;
    int            bad_count = 0, tests_run = 0, cyc = 0, seed = 98, hi, ri, d;
    int            tbl[4] = '{0, 2, 3, 4};

    always #5 CORE_CLK = ~CORE_CLK;
    // timer wraps to zero on period match
    always @(posedge CORE_CLK) cnt2 <= (cnt2 == PER) ? 16'h0000 : cnt2 + 16'h0001;
    assign TIMER2 = {cnt2, PER};
    assign TIMER3 = {16'h0000, 16'h0005};

    ocp_channel i_dut (.CORE_CLK, .RST, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB,
        .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA,
        .RRESP, .RVALID, .RREADY, .TIMER2, .TIMER3, .CPU_IDLE, .FAULT_INPUT_A_N,
        .FAULT_INPUT_B_N, .COMPARE_OUTPUT_PIN, .COMPARE_OUTPUT_OE, .CHANNEL_INTERRUPT_FLAG);
    ocp_load i_load (.PIN(COMPARE_OUTPUT_PIN), .OE(COMPARE_OUTPUT_OE), .TRIP(trip),
        .LEVEL(level), .FAULT_N(FAULT_INPUT_A_N));

    function automatic int pwm_hi(input int dd);
        return (dd > int'(PER)) ? int'(PER) + 1 : dd;
    endfunction : pwm_hi

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge CORE_CLK);
        AWADDR  <= a;
        WDATA   <= v;
        AWVALID <= 1'b1;
        WVALID  <= 1'b1;
        BREADY  <= 1'b1;
        do begin
            @(posedge CORE_CLK);
            if (AWREADY) AWVALID <= 1'b0;
            if (WREADY) WVALID <= 1'b0;
        end while (!BVALID);
        br = BRESP;
        BREADY <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge CORE_CLK);
        ARADDR  <= a;
        ARVALID <= 1'b1;
        RREADY  <= 1'b1;
        do begin
            @(posedge CORE_CLK);
            if (ARREADY) ARVALID <= 1'b0;
        end while (!RVALID);
        rv = RDATA;
        rr = RRESP;
        RREADY <= 1'b0;
    endtask : rd

    // high cycles and rising edges of the load level over n clocks
    task automatic meas(input int n);
        logic p;
        #1;
        hi = 0;
        ri = 0;
        p  = level;
        repeat (n) begin
            @(posedge CORE_CLK);
            #1;
            hi += int'(level);
            ri += int'(level & ~p);
            p  = level;
        end
    endtask : meas

    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : final_report

    always @(posedge CORE_CLK) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            final_report();
        end
    end

    initial begin
        repeat (3) @(posedge CORE_CLK);
        RST <= 1'b0;
        repeat (2) @(posedge CORE_CLK);
        rd(ADDR_CTRL);
        chk("ctrl reset", rv, 32'h0);
        wr(ADDR_CTRL, 32'hffff_ffff);
        chk("bresp okay", {30'h0, br}, {30'h0, RESP_OKAY});
        rd(ADDR_CTRL);
        chk("ctrl mask", rv, 32'h0000_200f);
        rd(8'h10);
        chk("unmapped", {30'h0, rr}, {30'h0, RESP_SLVERR});
        wr(8'h10, 32'h0000_0001);
        chk("wr unmapped", {30'h0, br}, {30'h0, RESP_SLVERR});
        wr(ADDR_CTRL, 32'h0);
        meas(8);
        chk("off oe", COMPARE_OUTPUT_OE, 1'b0);
        $display("test registers done");
        wr(ADDR_CTRL, 32'h6);
        for (int i = 0; i < 5; i++) begin
            d = (i < 4) ? tbl[i] : $unsigned($random(seed)) % 5;
            wr(ADDR_BUFFER, d);
            repeat (12) @(posedge CORE_CLK);
            meas(8);
            chk("pwm high", hi, 2 * pwm_hi(d));
            wr(ADDR_DUTY, 32'h00ff);
            rd(ADDR_DUTY);
            chk("duty", rv, d);
        end
        $display("test pwm done");
        wr(ADDR_CTRL, 32'h0);
        wr(ADDR_DUTY, 32'h2);
        wr(ADDR_BUFFER, 32'h3);
        wr(ADDR_CTRL, 32'h1);
        meas(8);
        chk("rise", level, 1'b1);
        wr(ADDR_CTRL, 32'h2);
        meas(8);
        chk("fall", level, 1'b0);
        wr(ADDR_CTRL, 32'h3);
        meas(16);
        chk("toggle", ri, 2);
        wr(ADDR_CTRL, 32'hb);
        meas(16);
        chk("timer3", ri, 0);
        @(posedge CORE_CLK);
        CPU_IDLE <= 1'b1;
        wr(ADDR_CTRL, 32'h2003);
        meas(16);
        chk("halt", ri, 0);
        @(posedge CORE_CLK);
        CPU_IDLE <= 1'b0;
        meas(16);
        chk("resume", ri, 2);
        wr(ADDR_CTRL, 32'h0);
        wr(ADDR_FLAG, 32'h1);
        wr(ADDR_CTRL, 32'h4);
        repeat (16) @(posedge CORE_CLK);
        meas(16);
        chk("single", ri, 0);
        chk("single flag", CHANNEL_INTERRUPT_FLAG, 1'b1);
        wr(ADDR_FLAG, 32'h1);
        wr(ADDR_CTRL, 32'h5);
        meas(16);
        chk("cont", ri, 4);
        chk("cont flag", CHANNEL_INTERRUPT_FLAG, 1'b1);
        $display("test compare modes done");
        wr(ADDR_CTRL, 32'h7);
        FAULT_INPUT_B_N <= 1'b0;
        repeat (4) @(posedge CORE_CLK);
        meas(8);
        chk("fault b", COMPARE_OUTPUT_OE, 1'b1);
        chk("fault b pwm", hi, 2 * pwm_hi(3));
        @(posedge CORE_CLK);
        FAULT_INPUT_B_N <= 1'b1;
        wr(ADDR_FLAG, 32'h1);
        trip <= 1'b1;
        repeat (8) @(posedge CORE_CLK);
        meas(8);
        chk("fault oe", COMPARE_OUTPUT_OE, 1'b0);
        chk("fault pin", hi, 0);
        chk("fault flag", CHANNEL_INTERRUPT_FLAG, 1'b1);
        rd(ADDR_CTRL);
        chk("fault status", rv, 32'h17);
        trip <= 1'b0;
        repeat (4) @(posedge CORE_CLK);
        wr(ADDR_CTRL, 32'h6);
        trip <= 1'b1;
        meas(8);
        chk("pwm oe", COMPARE_OUTPUT_OE, 1'b1);
        chk("no fault pwm", hi, 2 * pwm_hi(3));
        rd(ADDR_CTRL);
        chk("no fault", rv, 32'h6);
        $display("test fault done");
        final_report();
    end
endmodule : test_ocp_channel
